// [core/sigenc_defines.svh]
// Constants for the signalling tone strobe encoder
`ifndef SIGENC_DEFINES_SVH
`define SIGENC_DEFINES_SVH
`define SIGENC_STEPS_SUB     4'd12
`define SIGENC_STEPS_DTMF    4'd6
`define SIGENC_STEPS_DTMF_HI 4'd2
`define SIGENC_SYNC_STAGES   2
`define SIGENC_TAIL_NS       2000000
`define SIGENC_CLK_NS        10
`define SIGENC_TAIL_CYC      (`SIGENC_TAIL_NS / `SIGENC_CLK_NS)
`define SIGENC_IDLE_NS       20000000
`define SIGENC_IDLE_CYC      (`SIGENC_IDLE_NS / `SIGENC_CLK_NS)
`define SIGENC_ATTEN_RST     8'h80
`define SIGENC_CFG_W         16
`define SIGENC_CFG_SUBDEV_LO 0
`define SIGENC_CFG_SUBKIND   4
`define SIGENC_CFG_HIDEV     5
`define SIGENC_CFG_MODE_LO   6
`define SIGENC_CFG_DTMFHI    8
`define SIGENC_CFG_MODEM     9
`endif

// [core/sigenc_pkg.sv]
// Types shared by the signalling tone strobe encoder
package sigenc_pkg;
  typedef enum logic [1:0] {
    SIGENC_TX_IDLE,
    SIGENC_TX_SUB,
    SIGENC_TX_TRUNK,
    SIGENC_TX_DTMF
  } sigenc_mode_t;
  typedef enum logic {SIGENC_KIND_TONE, SIGENC_KIND_CODE} sigenc_kind_t;
endpackage

// [core/sigenc_step_if.sv]
// Strobe edge and step output bundle for one staircase generator
`timescale 1ns/10ps
interface sigenc_step_if;
  logic       step;
  logic [3:0] period;
  logic [3:0] phase;
  logic       active;
  modport gen (input step, input period, output phase, output active);
  modport use_ (output step, output period, input phase, input active);
endinterface

// [core/sigenc_stair.sv]
// Staircase phase generator, one step per strobe edge
`timescale 1ns/10ps
`include "sigenc_defines.svh"
module sigenc_stair (
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      clr_i,
  sigenc_step_if.gen     stp
);
  typedef struct packed {
    logic [3:0] phase;
    logic       active;
  } sigenc_stair_t;
  sigenc_stair_t st_ff;
  sigenc_stair_t nxt_st;

  // Wrap at the programmed step count
  always_comb begin
    nxt_st = st_ff;
    if (clr_i) begin
      nxt_st = '0;
    end else if (stp.step) begin
      nxt_st.active = 1'b1;
      if (st_ff.phase >= stp.period - 4'h1) begin
        nxt_st.phase = 4'h0;
      end else begin
        nxt_st.phase = st_ff.phase + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stp.phase  = st_ff.phase;
  assign stp.active = st_ff.active;
endmodule

// [core/sigenc_top.sv]
// Signalling encoder: strobe driven tone, data and DTMF generation
`timescale 1ns/10ps
`include "sigenc_defines.svh"
module sigenc_top #(
  parameter int unsigned TAIL_CYC = `SIGENC_TAIL_CYC,
  parameter int unsigned IDLE_CYC = `SIGENC_IDLE_CYC
) (
  input  wire logic                     REF_CLK_I,
  input  wire logic                     SYS_RST_I,
  input  wire logic [`SIGENC_CFG_W-1:0] CFG_I,
  input  wire logic                     CFG_LOAD_I,
  input  wire logic [7:0]               ATTEN_I,
  input  wire logic                     ATTEN_LOAD_I,
  input  wire logic                     SUB_STROBE_I,
  input  wire logic                     TRK_STROBE_I,
  input  wire logic                     LOW_STROBE_I,
  input  wire logic                     SQ_COMP_I,
  input  wire logic                     RX_SUB_I,
  input  wire logic signed [7:0]        MIC_I,
  input  wire logic signed [7:0]        RX_AUDIO_I,
  input  wire logic signed [7:0]        FLAT_AUDIO_I,
  output logic signed [9:0]             MOD_O,
  output logic signed [7:0]             RX_AUDIO_O,
  output logic signed [7:0]             EXT_AUDIO_O,
  output logic                          CHAN_ACT_O,
  output logic                          SQ_DET_O,
  output logic                          LIM_SUB_O,
  output logic                          MIC_MUTE_O
);
  // Position on the twelve step sine table for a phase and period
  function automatic logic [3:0] stair_index(input logic [3:0] ph,
                                             input logic [3:0] per);
    logic [3:0] idx;
    idx = 4'h0;
    case (per)
      `SIGENC_STEPS_DTMF: begin
        idx = ph * 4'h2;
      end
      // Two steps must land on peak and trough, not on zero crossings
      `SIGENC_STEPS_DTMF_HI: begin
        idx = (ph * 4'h6) + 4'h3;
      end
      default: begin
        idx = ph;
      end
    endcase
    return idx;
  endfunction

  // Sine staircase sample for a phase of a period-step cycle
  function automatic logic signed [7:0] stair(input logic [3:0] ph,
                                              input logic [3:0] per);
    case (stair_index(ph, per))
      4'h0: stair = 8'sh00;
      4'h1: stair = 8'sh20;
      4'h2: stair = 8'sh37;
      4'h3: stair = 8'sh40;
      4'h4: stair = 8'sh37;
      4'h5: stair = 8'sh20;
      4'h6: stair = 8'sh00;
      4'h7: stair = -8'sh20;
      4'h8: stair = -8'sh37;
      4'h9: stair = -8'sh40;
      4'ha: stair = -8'sh37;
      4'hb: stair = -8'sh20;
      default: stair = 8'sh00;
    endcase
  endfunction

  // Volume scaling: sample times setting over 256, sign kept
  function automatic logic signed [7:0] atten_scale(
      input logic signed [7:0] smp, input logic [7:0] att);
    logic [15:0] prod;
    prod = {{8{smp[7]}}, smp} * {8'h00, att};
    return prod[15:8];
  endfunction

  // Deviation: sample shifted down by four minus the level field
  function automatic logic signed [9:0] dev_scale(
      input logic signed [9:0] smp, input logic [1:0] dev, input logic hi);
    logic signed [9:0] res;
    res = smp >>> (3'h4 - {1'b0, dev});
    // Connect tone: same tone, one doubling of deviation
    if (hi) begin
      res = res <<< 1;
    end
    return res;
  endfunction

  // Two-flop synchronisers, plus an edge history stage on the three strobes
  typedef struct packed {
    logic [2:0] sub;
    logic [2:0] trk;
    logic [2:0] low;
    logic [1:0] sq;
    logic [1:0] rxs;
  } sigenc_sync_t;

  // Encoder state apart from the three generator phases, registered as one word
  typedef struct packed {
    sigenc_sync_t                sy;
    logic [`SIGENC_CFG_W-1:0]    cfg;
    logic [7:0]                  atten;
    logic                        code_lvl;
    logic [31:0]                 tail;
    logic [31:0]                 idle;
    logic                        busy;
    logic signed [9:0]           mod;
    logic signed [7:0]           rxa;
    logic signed [7:0]           ext;
    logic                        channel_activity_out;
    logic                        squelch_detect_out;
    logic                        lim;
    logic                        mute;
  } sigenc_st_t;

  sigenc_st_t       st_ff;
  sigenc_st_t       nxt_st;
  sigenc_pkg::sigenc_mode_t mode;
  sigenc_pkg::sigenc_kind_t kind;
  logic             sub_edge;
  logic             trk_edge;
  logic             low_edge;
  logic             clr;

  // Step bundles between the encoder and its three generators
  sigenc_step_if sub_if ();
  sigenc_step_if hi_if ();
  sigenc_step_if lo_if ();

  // Mode and kind fields of the loaded config word
  assign mode = sigenc_pkg::sigenc_mode_t'(
    st_ff.cfg[`SIGENC_CFG_MODE_LO +: 2]);
  assign kind = sigenc_pkg::sigenc_kind_t'(st_ff.cfg[`SIGENC_CFG_SUBKIND]);
  // Both strobe edges count, so a square wave gives two steps per period
  assign sub_edge = st_ff.sy.sub[2] ^ st_ff.sy.sub[1];
  assign trk_edge = st_ff.sy.trk[2] ^ st_ff.sy.trk[1];
  assign low_edge = st_ff.sy.low[2] ^ st_ff.sy.low[1];
  // A config load restarts every generator and the data level, unless a trunking edge toggles the level in the same cycle
  assign clr = CFG_LOAD_I;

  // Each generator only advances when its mode is selected
  assign sub_if.step   = sub_edge && (mode == sigenc_pkg::SIGENC_TX_SUB);
  assign sub_if.period = `SIGENC_STEPS_SUB;
  assign hi_if.step    = trk_edge && (mode == sigenc_pkg::SIGENC_TX_DTMF);
  assign hi_if.period  = st_ff.cfg[`SIGENC_CFG_DTMFHI] ?
                         `SIGENC_STEPS_DTMF_HI : `SIGENC_STEPS_DTMF;
  assign lo_if.step    = low_edge && (mode == sigenc_pkg::SIGENC_TX_DTMF);
  assign lo_if.period  = `SIGENC_STEPS_DTMF;

  // One staircase per tone source, all cleared by a config load
  sigenc_stair u_sub (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .clr_i (clr),
    .stp   (sub_if.gen)
  );
  sigenc_stair u_hi (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .clr_i (clr),
    .stp   (hi_if.gen)
  );
  sigenc_stair u_lo (
    .clk_i (REF_CLK_I),
    .rst_i (SYS_RST_I),
    .clr_i (clr),
    .stp   (lo_if.gen)
  );

  // Next state of the whole encoder
  always_comb begin
    logic signed [9:0] sig;
    logic signed [9:0] hi;
    logic signed [9:0] lo;
    logic signed [9:0] voice;
    sig   = 10'sh000;
    hi    = 10'sh000;
    lo    = 10'sh000;
    voice = 10'sh000;
    nxt_st = st_ff;
    // Sync shift; stage two feeds logic, stage three keeps edge history
    nxt_st.sy.sub = {st_ff.sy.sub[1:0], SUB_STROBE_I};
    nxt_st.sy.trk = {st_ff.sy.trk[1:0], TRK_STROBE_I};
    nxt_st.sy.low = {st_ff.sy.low[1:0], LOW_STROBE_I};
    nxt_st.sy.sq  = {st_ff.sy.sq[0], SQ_COMP_I};
    nxt_st.sy.rxs = {st_ff.sy.rxs[0], RX_SUB_I};
    // Host loads; a config load also resets the trunking level, unless the trunking toggle below fires in the same cycle
    if (CFG_LOAD_I) begin
      nxt_st.cfg      = CFG_I;
      nxt_st.code_lvl = 1'b0;
    end
    if (ATTEN_LOAD_I) begin
      nxt_st.atten = ATTEN_I;
    end
    // Idle timer notices that the host stopped strobing
    if (sub_edge || trk_edge || low_edge) begin
      nxt_st.idle = 32'(IDLE_CYC);
      nxt_st.busy = 1'b1;
    end else if (st_ff.idle != 32'h0) begin
      nxt_st.idle = st_ff.idle - 32'h1;
    end else begin
      nxt_st.busy = 1'b0;
    end
    // Two-state data level toggles on each trunking strobe edge, rising or falling
    if (trk_edge && mode == sigenc_pkg::SIGENC_TX_TRUNK) begin
      nxt_st.code_lvl = ~st_ff.code_lvl;
    end
    // Code kind reuses the sub strobe as a level pattern instead of a sine
    if (kind == sigenc_pkg::SIGENC_KIND_CODE) begin
      sig = st_ff.sy.sub[2] ? 10'sh040 : -10'sh040;
    end else begin
      sig = 10'(stair(sub_if.phase, sub_if.period));
    end
    // Sub deviation scale, plus one doubling for connect tone
    sig = dev_scale(sig, st_ff.cfg[`SIGENC_CFG_SUBDEV_LO +: 2],
                    st_ff.cfg[`SIGENC_CFG_HIDEV]);
    // Idle gate: no stray tone once the host stops strobing
    if (!sub_if.active || !st_ff.busy) begin
      sig = 10'sh000;
    end
    // Microphone path, replaced below in the data and DTMF modes
    voice = 10'(MIC_I);
    case (mode)
      sigenc_pkg::SIGENC_TX_SUB: begin
        nxt_st.mod  = voice + sig;
        nxt_st.mute = 1'b0;
      end
      sigenc_pkg::SIGENC_TX_TRUNK: begin
        nxt_st.mod  = st_ff.code_lvl ? 10'sh060 : -10'sh060;
        nxt_st.mute = 1'b1;
      end
      sigenc_pkg::SIGENC_TX_DTMF: begin
        // 5/4 weight is close to 2 dB of high group lift
        hi = 10'(stair(hi_if.phase, hi_if.period));
        hi = hi + (hi >>> 2);
        lo = 10'(stair(lo_if.phase, lo_if.period));
        nxt_st.mod  = st_ff.busy ? (hi + lo) : 10'sh000;
        nxt_st.mute = 1'b1;
      end
      default: begin
        nxt_st.mod  = voice;
        nxt_st.mute = 1'b0;
      end
    endcase
    // Squelch: comparator level, then a hold tail for the detect output
    nxt_st.channel_activity_out = st_ff.sy.sq[1];
    if (st_ff.channel_activity_out) begin
      nxt_st.tail  = 32'(TAIL_CYC);
      nxt_st.squelch_detect_out = 1'b1;
    end else if (st_ff.tail != 32'h0) begin
      nxt_st.tail = st_ff.tail - 32'h1;
    end else begin
      nxt_st.squelch_detect_out = 1'b0;
    end
    // Limited sub-audible level straight from the second sync stage
    nxt_st.lim = st_ff.sy.rxs[1];
    // Attenuation: audio times setting over 256
    nxt_st.rxa = atten_scale(RX_AUDIO_I, st_ff.atten);
    // External audio: flat in modem mode, else gated by squelch detect
    if (st_ff.cfg[`SIGENC_CFG_MODEM]) begin
      nxt_st.ext = FLAT_AUDIO_I;
    end else begin
      nxt_st.ext = st_ff.squelch_detect_out ? RX_AUDIO_I : 8'sh00;
    end
  end

  // Top-level state in one register; attenuator restarts at mid scale
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_ff       <= '0;
      st_ff.atten <= `SIGENC_ATTEN_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state flops
  assign MOD_O       = st_ff.mod;
  assign RX_AUDIO_O  = st_ff.rxa;
  assign EXT_AUDIO_O = st_ff.ext;
  assign CHAN_ACT_O  = st_ff.channel_activity_out;
  assign SQ_DET_O    = st_ff.squelch_detect_out;
  assign LIM_SUB_O   = st_ff.lim;
  assign MIC_MUTE_O  = st_ff.mute;
endmodule

// [bench/sigenc_top_properties.sv]
// Port-level assertions for the signalling encoder top
`timescale 1ns/10ps
`include "sigenc_defines.svh"
module sigenc_top_properties #(
  parameter int unsigned TAIL_CYC = 20
) (
  input wire logic                     REF_CLK_I,
  input wire logic                     SYS_RST_I,
  input wire logic [`SIGENC_CFG_W-1:0] CFG_I,
  input wire logic                     CFG_LOAD_I,
  input wire logic                     SQ_COMP_I,
  input wire logic                     RX_SUB_I,
  input wire logic signed [9:0]        MOD_O,
  input wire logic                     CHAN_ACT_O,
  input wire logic                     SQ_DET_O,
  input wire logic                     LIM_SUB_O,
  input wire logic                     MIC_MUTE_O
);
  localparam int TLO = TAIL_CYC - 8;
  localparam int THI = TAIL_CYC;
  logic [2:0] up_ff;
  logic [2:0] nxt_up_ff;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // Age since reset, so synchroniser history is never pre-reset
  always_comb nxt_up_ff = (up_ff == 3'h4) ? up_ff : up_ff + 3'h1;
  always_ff @(posedge REF_CLK_I) up_ff <= SYS_RST_I ? 3'h0 : nxt_up_ff;
  sequence act_drop;
    $fell(CHAN_ACT_O);
  endsequence
  sequence act_quiet;
    act_drop ##1 (!CHAN_ACT_O)[*8];
  endsequence
  chan_follow_a: assert property (up_ff == 3'h4 |->
    CHAN_ACT_O == $past(SQ_COMP_I, 3)) else $error("activity lag wrong");
  lim_follow_a: assert property (up_ff == 3'h4 |->
    LIM_SUB_O == $past(RX_SUB_I, 3)) else $error("limited out lag wrong");
  sq_follow_a: assert property (CHAN_ACT_O |=> SQ_DET_O)
    else $error("squelch detect not high");
  sq_hold_a: assert property (act_drop |-> SQ_DET_O[*8])
    else $error("squelch tail too short");
  sq_tail_a: assert property (act_quiet |-> ##[TLO:THI] !SQ_DET_O)
    else $error("squelch tail too long");
  mute_on_a: assert property (CFG_LOAD_I && CFG_I[7] |->
    ##2 MIC_MUTE_O) else $error("mic not muted");
  mute_off_a: assert property (CFG_LOAD_I && !CFG_I[7] |->
    ##2 !MIC_MUTE_O) else $error("mic muted outside data");
  reset_clear_a: assert property ($fell(SYS_RST_I) |->
    MOD_O == 10'sh000 && !CHAN_ACT_O && !SQ_DET_O)
    else $error("outputs not cleared");
endmodule
bind sigenc_top sigenc_top_properties #(.TAIL_CYC(TAIL_CYC)) u_props (
  .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .CFG_I(CFG_I),
  .CFG_LOAD_I(CFG_LOAD_I), .SQ_COMP_I(SQ_COMP_I), .RX_SUB_I(RX_SUB_I),
  .MOD_O(MOD_O), .CHAN_ACT_O(CHAN_ACT_O), .SQ_DET_O(SQ_DET_O),
  .LIM_SUB_O(LIM_SUB_O), .MIC_MUTE_O(MIC_MUTE_O));

// [bench/sigenc_host_model.sv]
// Host strobe source for the three encoder strobe pins
`timescale 1ns/10ps
module sigenc_host_model (
  input  wire logic [2:0] en_i,
  output logic      [2:0] strobe_o
);
  // Fixed 160 ns square wave, moving 1 ns after a core clock edge
  initial begin
    strobe_o = 3'h0;
    #26;
    forever begin
      #80;
      strobe_o = strobe_o ^ en_i;
    end
  end
endmodule

// [bench/sigenc_top_tb_top.sv]
// Self-checking bench for the signalling encoder top
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("BAD %s exp %h got %h", n, e, a); end end
module sigenc_top_tb_top;
  logic clk, rst, ld, ald, sq, rxs, ca, sd, lim, mm;
  logic [15:0] cfg;
  logic [7:0] att;
  logic signed [7:0] mic, rxa, fla, rxo, exo;
  logic signed [9:0] mod, m1, p1, p2;
  logic [2:0] en, stb;
  logic per;
  int mismatches, checks_done;
  sigenc_top #(.TAIL_CYC(20), .IDLE_CYC(50)) dut (.REF_CLK_I(clk),
    .SYS_RST_I(rst), .CFG_I(cfg), .CFG_LOAD_I(ld), .ATTEN_I(att),
    .ATTEN_LOAD_I(ald), .SUB_STROBE_I(stb[0]), .TRK_STROBE_I(stb[1]),
    .LOW_STROBE_I(stb[2]), .SQ_COMP_I(sq), .RX_SUB_I(rxs), .MIC_I(mic),
    .RX_AUDIO_I(rxa), .FLAT_AUDIO_I(fla), .MOD_O(mod), .RX_AUDIO_O(rxo),
    .EXT_AUDIO_O(exo), .CHAN_ACT_O(ca), .SQ_DET_O(sd), .LIM_SUB_O(lim),
    .MIC_MUTE_O(mm));
  sigenc_host_model u_host (.en_i(en), .strobe_o(stb));
  // Core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Config word: modem, high group x2, mode, connect level, kind, dev 3
  function automatic logic [15:0] mk(input logic [1:0] m, input logic k,
                                     input logic h, input logic d);
    return {7'h00, d, m, h, k, 4'h3};
  endfunction
  task automatic load(input logic [15:0] v);
    cfg = v;
    ld = 1'b1;
    cyc(1);
    ld = 1'b0;
    cyc(3);
  endtask
  // Wait for one strobe edge, then for the step to land on MOD_O
  task automatic step(input int s);
    logic l;
    int i;
    l = stb[s];
    for (i = 0; i < 40 && stb[s] === l; i++) cyc(1);
    if (i == 40) begin
      mismatches++;
      print_verdict();
    end
    cyc(6);
  endtask
  // Runs n+1 strobe edges; peak value and whole-cycle repeat
  task automatic sweep(input int s, input int n,
                       output logic signed [9:0] pk, output logic rep);
    logic signed [9:0] m0;
    pk = 10'sh000;
    en[s] = 1'b1;
    for (int i = 0; i <= n; i++) begin
      step(s);
      if (i == 0) m0 = mod;
      if (mod > pk) pk = mod;
    end
    rep = (mod === m0);
    en = 3'h0;
  endtask
  task automatic t_att();
    rxa = 8'sh40;
    cyc(2);
    `CHK("att_rst", 8'sh20, rxo)
    att = 8'hff;
    ald = 1'b1;
    cyc(1);
    ald = 1'b0;
    cyc(2);
    `CHK("att_max", 8'sh3f, rxo)
  endtask
  task automatic t_sq();
    load(16'h0000);
    rxa = 8'sh25;
    sq = 1'b1;
    cyc(6);
    `CHK("channel_activity_out", 1'b1, ca)
    `CHK("ext_gate", rxa, exo)
    sq = 1'b0;
    cyc(6);
    `CHK("channel_activity_out_off", 1'b0, ca)
    `CHK("sq_tail", 1'b1, sd)
    cyc(24);
    `CHK("sq_off", 1'b0, sd)
    `CHK("ext_mute", 8'sh00, exo)
    load(16'h0200);
    fla = 8'sh5a;
    cyc(3);
    `CHK("ext_flat", fla, exo)
  endtask
  task automatic t_lim();
    rxs = 1'b1;
    cyc(5);
    `CHK("lim_hi", 1'b1, lim)
    rxs = 1'b0;
    cyc(5);
    `CHK("lim_lo", 1'b0, lim)
  endtask
  task automatic t_sub();
    load(mk(sigenc_pkg::SIGENC_TX_SUB, 1'b0, 1'b0, 1'b0));
    sweep(0, 12, p1, per);
    `CHK("sub_period", 1'b1, per)
    load(mk(sigenc_pkg::SIGENC_TX_SUB, 1'b0, 1'b1, 1'b0));
    sweep(0, 12, p2, per);
    `CHK("connect_lvl", 1'b1, p2 > p1)
    load(mk(sigenc_pkg::SIGENC_TX_SUB, 1'b1, 1'b0, 1'b0));
    en = 3'h1;
    for (int i = 0; i < 2; i++) begin
      step(0);
      `CHK("code_lvl", stb[0], mod > 10'sh000)
    end
    en = 3'h0;
  endtask
  task automatic t_trk();
    load(mk(sigenc_pkg::SIGENC_TX_TRUNK, 1'b0, 1'b0, 1'b0));
    mic = 8'sh30;
    `CHK("mute_trk", 1'b1, mm)
    en = 3'h2;
    step(1);
    m1 = mod;
    step(1);
    `CHK("trk_flip", 1'b1, (m1 < 0) != (mod < 0))
    en = 3'h1;
    m1 = mod;
    step(0);
    `CHK("sub_ignored", m1, mod)
    en = 3'h0;
    mic = 8'sh00;
  endtask
  task automatic t_dtmf();
    load(mk(sigenc_pkg::SIGENC_TX_DTMF, 1'b0, 1'b0, 1'b0));
    `CHK("mute_dtmf", 1'b1, mm)
    sweep(2, 6, p1, per);
    `CHK("low_period", 1'b1, per)
    load(mk(sigenc_pkg::SIGENC_TX_DTMF, 1'b0, 1'b0, 1'b0));
    sweep(1, 6, p2, per);
    `CHK("high_period", 1'b1, per)
    `CHK("high_weight", 1'b1, p2 > p1)
    load(mk(sigenc_pkg::SIGENC_TX_DTMF, 1'b0, 1'b0, 1'b1));
    sweep(1, 2, p2, per);
    `CHK("high_x2", 1'b1, per)
    `CHK("high_x2_amp", 1'b1, p2 > 10'sh000)
  endtask
  // Main sequence
  initial begin
    {rst, ld, ald, sq, rxs} = 5'h10;
    {cfg, att, mic, rxa, fla, en} = '0;
    mismatches = 0;
    checks_done = 0;
    cyc(8);
    rst = 1'b0;
    cyc(1);
    `CHK("mod_rst", 10'sh000, mod)
    t_att();
    t_sq();
    t_lim();
    t_sub();
    t_trk();
    t_dtmf();
    print_verdict();
  end
endmodule
